// ===== rtl/interprocessor_event_hub.sv
/*
  Interprocessor event hub: APB register file, send and receive channel
  mapping, routing fabric publish and subscribe, interrupt and scratch words.
  Assumes shared channels are OR-wired outside between all peer hubs, and that
  the routing fabric runs on pclk with one-cycle event pulses.
*/
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module interprocessor_event_hub #(
  parameter int unsigned NUM_CH    = 16,
  parameter int unsigned ROUTE_CH  = 16
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [event_hub_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  output logic                                   pready,
  output logic      [31:0]                       prdata,
  output logic                                   pslverr,
  input  wire logic [NUM_CH-1:0]                 ch_in,
  output logic      [NUM_CH-1:0]                 ch_out,
  input  wire logic [ROUTE_CH-1:0]               route_in,
  output logic      [ROUTE_CH-1:0]               route_out,
  output logic                                   irq
);
  import event_hub_pkg::*;

  logic [IDX_W-1:0]  sub_idx_q   [NUM_TASKS];
  logic              sub_en_q    [NUM_TASKS];
  logic [IDX_W-1:0]  pub_idx_q   [NUM_TASKS];
  logic              pub_en_q    [NUM_TASKS];
  logic [NUM_CH-1:0] send_mask_q [NUM_TASKS];
  logic [NUM_CH-1:0] recv_mask_q [NUM_TASKS];
  logic [31:0]       scratch_q   [NUM_SCRATCH];
  logic [NUM_TASKS-1:0] flag_q;
  logic [NUM_TASKS-1:0] flag_d;
  logic [NUM_TASKS-1:0] irq_enable_mask_q;
  logic [NUM_TASKS-1:0] irq_enable_mask_d;
  logic [ROUTE_CH-1:0]  route_out_d;
  logic [31:0]          rd_data;

  function automatic logic pick_route(input logic [ROUTE_CH-1:0] ev,
                                      input logic [IDX_W-1:0] idx);
    logic r;
    r = 1'b0;
    for (int k = 0; k < ROUTE_CH; k++) begin
      if (idx == IDX_W'(k)) begin
        r = ev[k];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] route_word(input logic [IDX_W-1:0] idx,
                                             input logic en);
    logic [31:0] w;
    w = RESET_WORD;
    w[ROUTE_IDX_LSB +: IDX_W] = idx;
    w[ROUTE_EN_BIT] = en;
    return w;
  endfunction

  // Bus decode. The slave answers one cycle into the access phase.
  wire access_done = psel & penable & pready;
  wire wr_done     = access_done & pwrite;
  wire [2:0] idx_trig  = word_index(paddr, OFF_SEND_TRIGGER);
  wire [2:0] idx_sub   = word_index(paddr, OFF_SEND_SUB);
  wire [2:0] idx_flag  = word_index(paddr, OFF_RECEIVE_FLAG);
  wire [2:0] idx_pub   = word_index(paddr, OFF_RECEIVE_PUB);
  wire [2:0] idx_smask = word_index(paddr, OFF_CH_SEND_MASK);
  wire [2:0] idx_rmask = word_index(paddr, OFF_CH_RECV_MASK);
  wire [2:0] idx_scr   = word_index(paddr, OFF_SCRATCH);
  wire hit_trig  = in_array(paddr, OFF_SEND_TRIGGER, NUM_TASKS);
  wire hit_sub   = in_array(paddr, OFF_SEND_SUB, NUM_TASKS);
  wire hit_flag  = in_array(paddr, OFF_RECEIVE_FLAG, NUM_TASKS);
  wire hit_pub   = in_array(paddr, OFF_RECEIVE_PUB, NUM_TASKS);
  wire hit_irq_enable_mask = (paddr == OFF_IRQ_ENABLE);
  wire hit_set   = (paddr == OFF_IRQ_SET);
  wire hit_clr   = (paddr == OFF_IRQ_CLEAR);
  wire hit_pend  = (paddr == OFF_IRQ_PENDING);
  wire hit_smask = in_array(paddr, OFF_CH_SEND_MASK, NUM_TASKS);
  wire hit_rmask = in_array(paddr, OFF_CH_RECV_MASK, NUM_TASKS);
  wire hit_scr   = in_array(paddr, OFF_SCRATCH, NUM_SCRATCH);
  wire mapped    = hit_trig | hit_sub | hit_flag | hit_pub | hit_irq_enable_mask |
                   hit_set | hit_clr | hit_pend | hit_smask | hit_rmask |
                   hit_scr;

  // Send side: software writes and subscribed fabric events both trigger.
  logic [NUM_TASKS-1:0] trig;
  logic [NUM_CH-1:0]    send_fire;
  for (genvar n = 0; n < NUM_TASKS; n++) begin : g_trig
    wire sw_trig = wr_done & hit_trig & (idx_trig == 3'(n)) &
                   pwdata[TRIGGER_BIT];
    wire hw_trig = sub_en_q[n] & pick_route(route_in, sub_idx_q[n]);
    assign trig[n] = sw_trig | hw_trig;
  end

  always_comb begin
    send_fire = '0;
    for (int n = 0; n < NUM_TASKS; n++) begin
      if (trig[n]) begin
        send_fire = send_fire | send_mask_q[n];
      end
    end
  end

  // Several local tasks on one channel merge into one pulse, like peers do.
  pulse_stretcher #(
    .WIDTH (NUM_CH),
    .LEN   (CH_PULSE_CYCLES)
  ) u_stretch (
    .pclk    (pclk),
    .presetn (presetn),
    .fire    (send_fire),
    .level   (ch_out)
  );

  // Peer hubs may sit on other clocks, so the wired channels are synchronised.
  logic [NUM_CH-1:0] ch_rise;
  bit_sync_rise #(
    .WIDTH (NUM_CH)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ch_in),
    .rise     (ch_rise)
  );

  // Receive side. A set in the same cycle as a software clear wins.
  logic [NUM_TASKS-1:0] recv_hit;
  for (genvar n = 0; n < NUM_TASKS; n++) begin : g_recv
    assign recv_hit[n] = |(ch_rise & recv_mask_q[n]);
    wire flag_wr = wr_done & hit_flag & (idx_flag == 3'(n));
    assign flag_d[n] = recv_hit[n] |
                       (flag_wr ? pwdata[FLAG_BIT] : flag_q[n]);
  end

  always_comb begin
    route_out_d = '0;
    for (int n = 0; n < NUM_TASKS; n++) begin
      for (int k = 0; k < ROUTE_CH; k++) begin
        if (recv_hit[n] && pub_en_q[n] && pub_idx_q[n] == IDX_W'(k)) begin
          route_out_d[k] = 1'b1;
        end
      end
    end
  end

  // Interrupt enables: plain write, write-one-set and write-one-clear.
  always_comb begin
    irq_enable_mask_d = irq_enable_mask_q;
    if (wr_done && hit_irq_enable_mask) begin
      irq_enable_mask_d = pwdata[NUM_TASKS-1:0];
    end
    if (wr_done && hit_set) begin
      irq_enable_mask_d = irq_enable_mask_q | pwdata[NUM_TASKS-1:0];
    end
    if (wr_done && hit_clr) begin
      irq_enable_mask_d = irq_enable_mask_q & ~pwdata[NUM_TASKS-1:0];
    end
  end

  wire [NUM_TASKS-1:0] pending = flag_q & irq_enable_mask_q;

  // Read data. Trigger words read as zero.
  always_comb begin
    rd_data = RESET_WORD;
    if (hit_sub) begin
      rd_data = route_word(sub_idx_q[idx_sub], sub_en_q[idx_sub]);
    end
    if (hit_flag) begin
      rd_data[FLAG_BIT] = flag_q[idx_flag];
    end
    if (hit_pub) begin
      rd_data = route_word(pub_idx_q[idx_pub], pub_en_q[idx_pub]);
    end
    if (hit_irq_enable_mask || hit_set || hit_clr) begin
      rd_data[NUM_TASKS-1:0] = irq_enable_mask_q;
    end
    if (hit_pend) begin
      rd_data[NUM_TASKS-1:0] = pending;
    end
    if (hit_smask) begin
      rd_data[NUM_CH-1:0] = send_mask_q[idx_smask];
    end
    if (hit_rmask) begin
      rd_data[NUM_CH-1:0] = recv_mask_q[idx_rmask];
    end
    if (hit_scr) begin
      rd_data = scratch_q[idx_scr[1:0]];
    end
  end

  // Bus answer flops: pready rises one edge into the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= RESET_WORD;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_data : RESET_WORD;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // Status, enables, routing pulses and the interrupt line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q    <= '0;
      irq_enable_mask_q   <= '0;
      route_out <= '0;
      irq       <= 1'b0;
    end else begin
      flag_q    <= flag_d;
      irq_enable_mask_q   <= irq_enable_mask_d;
      route_out <= route_out_d;
      irq       <= |(flag_d & irq_enable_mask_d);
    end
  end

  // Configuration words.
  for (genvar n = 0; n < NUM_TASKS; n++) begin : g_cfg
    wire w_sub = wr_done & hit_sub   & (idx_sub == 3'(n));
    wire w_pub = wr_done & hit_pub   & (idx_pub == 3'(n));
    wire w_sm  = wr_done & hit_smask & (idx_smask == 3'(n));
    wire w_rm  = wr_done & hit_rmask & (idx_rmask == 3'(n));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sub_idx_q[n]   <= '0;
        sub_en_q[n]    <= 1'b0;
        pub_idx_q[n]   <= '0;
        pub_en_q[n]    <= 1'b0;
        send_mask_q[n] <= '0;
        recv_mask_q[n] <= '0;
      end else begin
        if (w_sub) begin
          sub_idx_q[n] <= pwdata[ROUTE_IDX_LSB +: IDX_W];
          sub_en_q[n]  <= pwdata[ROUTE_EN_BIT];
        end
        if (w_pub) begin
          pub_idx_q[n] <= pwdata[ROUTE_IDX_LSB +: IDX_W];
          pub_en_q[n]  <= pwdata[ROUTE_EN_BIT];
        end
        if (w_sm) begin
          send_mask_q[n] <= pwdata[NUM_CH-1:0];
        end
        if (w_rm) begin
          recv_mask_q[n] <= pwdata[NUM_CH-1:0];
        end
      end
    end
  end

  // Scratch words are lost at reset, which stands in for leaving the on state.
  for (genvar s = 0; s < NUM_SCRATCH; s++) begin : g_scr
    wire w_scr = wr_done & hit_scr & (idx_scr == 3'(s));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scratch_q[s] <= RESET_WORD;
      end else if (w_scr) begin
        scratch_q[s] <= pwdata;
      end
    end
  end
endmodule
`default_nettype wire

// ===== include/event_hub_pkg.sv
/*
  Constants, register map and decode helpers for the interprocessor event
  hub. Assumes a 200 MHz APB clock and a 12-bit word-aligned APB address.
*/
`default_nettype none
package event_hub_pkg;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned NUM_TASKS   = 8;
  localparam int unsigned NUM_SCRATCH = 4;
  localparam int unsigned IDX_W       = 8;

  localparam logic [11:0] OFF_SEND_TRIGGER   = 12'h000;
  localparam logic [11:0] OFF_SEND_SUB       = 12'h080;
  localparam logic [11:0] OFF_RECEIVE_FLAG   = 12'h100;
  localparam logic [11:0] OFF_RECEIVE_PUB    = 12'h180;
  localparam logic [11:0] OFF_IRQ_ENABLE     = 12'h300;
  localparam logic [11:0] OFF_IRQ_SET        = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLEAR      = 12'h308;
  localparam logic [11:0] OFF_IRQ_PENDING    = 12'h30c;
  localparam logic [11:0] OFF_CH_SEND_MASK   = 12'h510;
  localparam logic [11:0] OFF_CH_RECV_MASK   = 12'h590;
  localparam logic [11:0] OFF_SCRATCH        = 12'h610;

  localparam int unsigned ROUTE_IDX_LSB = 0;
  localparam int unsigned ROUTE_EN_BIT  = 31;
  localparam int unsigned TRIGGER_BIT   = 0;
  localparam int unsigned FLAG_BIT      = 0;

  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned MERGE_WINDOW_US = 165;
  localparam int unsigned CH_PULSE_NS     = 20;
  localparam int unsigned CH_PULSE_CYCLES =
    (CH_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  function automatic logic in_array(input logic [11:0] a,
                                    input logic [11:0] base,
                                    input int unsigned n);
    logic [11:0] top;
    top = base + 12'(n * 4);
    return (a >= base) && (a < top) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] word_index(input logic [11:0] a,
                                            input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[4:2];
  endfunction
endpackage
`default_nettype wire

// ===== rtl/bit_sync_rise.sv
/*
  Two-flop synchroniser per bit followed by a rising-edge detector.
  Assumes inputs may come from a foreign clock and stay high one edge or more.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_sync_rise #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;

  // A long high level counts once, so overlapping drives merge here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
endmodule
`default_nettype wire

// ===== rtl/pulse_stretcher.sv
/*
  Holds each bit high for LEN cycles after its last fire pulse.
  Assumes fire comes from logic on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_stretcher #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned LEN   = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] fire,
  output logic      [WIDTH-1:0] level
);
  localparam int unsigned CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LOAD = CW'(LEN);

  logic [CW-1:0] cnt_q [WIDTH];

  // The stretch lets a slower peer clock see the event.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q[i] <= '0;
        level[i] <= 1'b0;
      end else if (fire[i]) begin
        cnt_q[i] <= LOAD - CW'(1);
        level[i] <= 1'b1;
      end else if (cnt_q[i] != '0) begin
        cnt_q[i] <= cnt_q[i] - CW'(1);
        level[i] <= 1'b1;
      end else begin
        level[i] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/event_hub_props.sv
/*
  Port-level checker for the interprocessor event hub.
  Assumes it is bound onto the hub and shares its single clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module event_hub_props #(
  parameter int unsigned NUM_CH   = 16,
  parameter int unsigned ROUTE_CH = 16
) (
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [event_hub_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                      pwdata,
  input wire logic                             pready,
  input wire logic [31:0]                      prdata,
  input wire logic                             pslverr,
  input wire logic [NUM_CH-1:0]                ch_in,
  input wire logic [NUM_CH-1:0]                ch_out,
  input wire logic [ROUTE_CH-1:0]              route_in,
  input wire logic [ROUTE_CH-1:0]              route_out,
  input wire logic                             irq
);
  import event_hub_pkg::*;
  wire apb_wr    = psel && penable && pready && pwrite;
  wire trig_wr   = apb_wr && (paddr < OFF_SEND_SUB) && pwdata[TRIGGER_BIT];
  wire route_any = |route_in;
  wire ch_any    = |ch_in;
  wire ch_idle   = (ch_out == '0);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence access_wait;
    psel && penable && !pready;
  endsequence
  sequence access_done;
    psel && penable && pready;
  endsequence
  // A one-cycle pulse is all the hub gives, so a slow master must not miss it.
  a_pready_one_wait: assert property (access_wait |=> access_done)
    else $error("pready not given one cycle into the access phase");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside an answer");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside an answer");
  a_send_width: assert property ($rose(ch_out[0]) |-> ch_out[0] [*4])
    else $error("channel event shorter than four cycles");
  a_send_cause: assert property (!ch_idle && $past(ch_idle) |->
      $past(trig_wr) || $past(route_any))
    else $error("channel event without a trigger");
  // Two sync flops and the route_out flop put the cause exactly three edges back.
  a_publish_cause: assert property (route_out != '0 |->
      $past(ch_any, 3))
    else $error("publish pulse without a received event");
  a_irq_hold: assert property (irq && !(psel && pwrite) && !$past(apb_wr)
      |=> irq)
    else $error("irq dropped without a software write");
endmodule
bind interprocessor_event_hub event_hub_props #(
  .NUM_CH(NUM_CH), .ROUTE_CH(ROUTE_CH)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .ch_in(ch_in), .ch_out(ch_out),
  .route_in(route_in), .route_out(route_out), .irq(irq));
`default_nettype wire

// ===== sim/peer_event_model.sv
/*
  Behavioural peer hubs on the shared channels.
  Assumes the bench calls fire() and keeps events on one channel far apart.
*/
`timescale 1ns/1ps
`default_nettype none
module peer_event_model (
  input  wire logic        pclk,
  input  wire logic [15:0] ch_out,
  input  wire logic        loop_en,
  output logic      [15:0] ch_in
);
  logic [15:0] drive_q = 16'h0000;
  // Channels are wired-OR, so a clash of drivers is simply merged.
  assign ch_in = drive_q | (loop_en ? ch_out : 16'h0000);
  // Each event is held four cycles and then released to idle low.
  task automatic fire(input logic [15:0] m);
    @(posedge pclk);
    drive_q <= m;
    repeat (4) @(posedge pclk);
    drive_q <= 16'h0000;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_interprocessor_event_hub.sv
/*
  Self-checking bench for the interprocessor event hub over APB.
  Assumes the checker is bound and the peer model drives the channels.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_interprocessor_event_hub;
  import event_hub_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, loop_en = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, irq, err_seen;
  logic [15:0] ch_in, ch_out, route_out, route_in = 16'h0;
  logic [15:0] route_last = 16'h0;
  int          errors = 0, n_checks = 0, cyc = 0;
  logic [11:0] offs[8] = '{OFF_SEND_SUB, OFF_RECEIVE_FLAG, OFF_RECEIVE_PUB,
    OFF_IRQ_ENABLE, OFF_IRQ_PENDING, OFF_CH_SEND_MASK, OFF_CH_RECV_MASK,
    OFF_SCRATCH};

  interprocessor_event_hub DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ch_in(ch_in),
    .ch_out(ch_out), .route_in(route_in), .route_out(route_out), .irq(irq));
  peer_event_model peer (.pclk(pclk), .ch_out(ch_out), .loop_en(loop_en),
    .ch_in(ch_in));

  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) if (route_out != 16'h0) route_last <= route_out;
  // The ceiling is far above the expected run, so only a hang reaches it.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input string what);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp, what);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    logic [15:0] m;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0, "reset value");
    rd(OFF_SEND_TRIGGER, 32'h0, "trigger reads zero");
    #1 chk(32'(ch_out), 32'h0, "read fires nothing");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_SCRATCH + 12'(4 * i), 32'ha5a5_0000 | 32'(i));
    end
    for (int i = 0; i < 4; i++) begin
      rd(OFF_SCRATCH + 12'(4 * i), 32'ha5a5_0000 | 32'(i), "scratch");
    end
    chk(32'(err_seen), 32'h0, "mapped error");
    apb(1'b1, OFF_SCRATCH + 12'h002, 32'hffff_ffff);
    chk(32'(err_seen), 32'h1, "unaligned error");
    rd(OFF_SCRATCH, 32'ha5a5_0000, "unaligned ignored");
    rd(12'h7fc, 32'h0, "unmapped read");
    chk(32'(err_seen), 32'h1, "unmapped error");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_SCRATCH + 12'h00c, 32'h0, "scratch after reset");
    $display("test scratch done");
    for (int n = 0; n < 8; n++) begin
      m = (16'h0001 << n) | (16'h0100 << n);
      apb(1'b1, OFF_CH_SEND_MASK + 12'(4 * n), 32'(m));
      apb(1'b1, OFF_SEND_TRIGGER + 12'(4 * n), 32'h1);
      #1 chk(32'(ch_out), 32'(m), "send channels");
    end
    apb(1'b1, OFF_SEND_SUB, 32'h8000_0003);
    @(posedge pclk);
    route_in <= 16'h0008;
    @(posedge pclk);
    route_in <= 16'h0000;
    #1 chk(32'(ch_out), 32'h0101, "subscribed send");
    $display("test send done");
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, OFF_CH_RECV_MASK + 12'(4 * n), 32'h3 << (2 * n));
      apb(1'b1, OFF_RECEIVE_PUB + 12'(4*n), 32'h8000_0000 | 32'(n+8));
      apb(1'b1, OFF_IRQ_SET, 32'h1 << n);
      peer.fire(16'h0002 << (2 * n));
      repeat (8) @(posedge pclk);
      rd(OFF_RECEIVE_FLAG + 12'(4 * n), 32'h1, "receive flag");
      rd(OFF_IRQ_PENDING, 32'h1 << n, "pending");
      chk(32'(irq), 32'h1, "irq raised");
      chk(32'(route_last), 32'h100 << n, "publish channel");
      apb(1'b1, OFF_RECEIVE_FLAG + 12'(4 * n), 32'h0);
      rd(OFF_RECEIVE_FLAG + 12'(4 * n), 32'h0, "flag cleared");
      chk(32'(irq), 32'h0, "irq dropped");
      apb(1'b1, OFF_IRQ_CLEAR, 32'h1 << n);
      rd(OFF_IRQ_ENABLE, 32'h0, "enable cleared");
    end
    $display("test receive done");
    apb(1'b1, OFF_RECEIVE_FLAG, 32'h1);
    rd(OFF_IRQ_PENDING, 32'h0, "masked pending");
    chk(32'(irq), 32'h0, "masked irq");
    apb(1'b1, OFF_IRQ_SET, 32'h1);
    apb(1'b1, OFF_IRQ_SET, 32'h0);
    rd(OFF_IRQ_SET, 32'h1, "set ignores zero");
    rd(OFF_IRQ_PENDING, 32'h1, "unmasked pending");
    chk(32'(irq), 32'h1, "unmasked irq");
    apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
    rd(OFF_IRQ_PENDING, 32'h0, "cleared pending");
    chk(32'(irq), 32'h0, "irq after clear");
    apb(1'b1, OFF_RECEIVE_FLAG, 32'h0);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_00a5);
    rd(OFF_IRQ_CLEAR, 32'h0000_00a5, "enable mask write");
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
    rd(OFF_IRQ_SET, 32'h0, "enable mask cleared");
    $display("test irq done");
    loop_en <= 1'b1;
    fork
      peer.fire(16'h0001);
      apb(1'b1, OFF_SEND_TRIGGER, 32'h1);
    join
    repeat (8) @(posedge pclk);
    rd(OFF_RECEIVE_FLAG, 32'h1, "merged channel");
    chk(32'(irq), 32'h0, "no irq while disabled");
    $display("test shared channel done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
